// [verilog/fault_app_params.svh]
// Contract
// [R1] the fault reason byte reports 0 none, 1 cooler runaway, 2 data memory corrupt, 3 program memory corrupt, 32-63 custom, others reserved.
// [R2] the fault reason byte exists only when paged memory is implemented.
// [R3] lower memory bytes 86-117 hold bytes 0-3 of eight descriptors, four bytes each.
// [R4] at least one application is always advertised in the first slot.
// [R5] the first unused slot carries FFh as host interface code and ends the list.
// [R6] the host reads media interface codes through the media kind byte at 85.
// [R7] media kind is 00h undefined, 01h-05h defined kinds, 40h-8Fh custom, rest reserved.
// [R8] descriptor byte 2 holds host lane total in 7-4 and media lane total in 3-0, 0 deferred, 1-8 lanes, 9-15 reserved.
// [R9] descriptor byte 3 is a bitmap, bit n meaning the group may start on host lane n+1.
// [R10] descriptor bytes are host code, media code, lane totals, start lane map.
// [R11] the fifth descriptor byte lives elsewhere, not in this region.
// [R12] a descriptor's selector equals its position, starting at 1.
// [R13] descriptors beyond eight live in extended memory, not here.
// [R14] host writes leave every byte here unchanged.
// [R15] contents are captured once and held stable while operating.
`ifndef FAULT_APP_PARAMS_SVH
`define FAULT_APP_PARAMS_SVH
`define FAULT_REASON_ADDR 8'h29
`define MEDIA_KIND_ADDR   8'h55
`define APP_BASE_ADDR     8'h56
`define APP_LAST_ADDR     8'h75
`define APP_SLOTS         8
`define APP_BYTES         4
`define LIST_END_CODE     8'hFF
`define FAULT_NONE        8'h00
`define FAULT_CUSTOM_LO   8'h20
`define FAULT_CUSTOM_HI   8'h3F
`define FAULT_KNOWN_HI    8'h03
`define MEDIA_KNOWN_HI    8'h05
`define MEDIA_CUSTOM_LO   8'h40
`define MEDIA_CUSTOM_HI   8'h8F
`define LANES_MAX         4'h8
`define RESET_READ_VALUE  8'h00
`endif

// [verilog/fault_app_pkg.sv]
package fault_app_pkg;
  // one application descriptor, relative bytes 0..3
  typedef struct packed {
    logic [7:0] host_code;
    logic [7:0] media_code;
    logic [3:0] host_lane_total;
    logic [3:0] media_lane_total;
    logic [7:0] start_lanes;
  } app_desc_s;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_RUN  = 2'b01
  } bank_state_e;
endpackage : fault_app_pkg

// [verilog/app_table_if.sv]
`timescale 1ns/1ps
// carries the frozen descriptor table between bank and its lookup
interface app_table_if;
  fault_app_pkg::app_desc_s table_q [8];
  logic                     [7:0] addr;
  logic                     [7:0] data;
  logic                     hit;
  modport bank (output table_q, output addr, input data, input hit);
  modport look (input table_q, input addr, output data, output hit);
endinterface : app_table_if

// [verilog/app_lookup.sv]
`timescale 1ns/1ps
`include "fault_app_params.svh"
module app_lookup (
  app_table_if.look t
);
  logic [7:0] rel;
  logic [2:0] slot;
  logic [7:0] bytes [`APP_SLOTS][`APP_BYTES];

  // field order inside a descriptor
  genvar g;
  generate
    for (g = 0; g < `APP_SLOTS; g = g + 1) begin : g_slot
      assign bytes[g][0] = t.table_q[g].host_code;            // [R10]
      assign bytes[g][1] = t.table_q[g].media_code;           // [R10]
      assign bytes[g][2] = {t.table_q[g].host_lane_total,
                            t.table_q[g].media_lane_total};   // [R8]
      assign bytes[g][3] = t.table_q[g].start_lanes;          // [R9]
    end
  endgenerate

  // slot = selector minus one, four bytes per slot
  always_comb begin
    rel    = t.addr - `APP_BASE_ADDR;                         // [R3]
    slot   = rel[4:2];                                        // [R12]
    t.hit  = (t.addr >= `APP_BASE_ADDR) && (t.addr <= `APP_LAST_ADDR);
    t.data = t.hit ? bytes[slot][rel[1:0]] : `RESET_READ_VALUE;
  end
endmodule : app_lookup

// [verilog/fault_app_bank.sv]
`timescale 1ns/1ps
`include "fault_app_params.svh"
module fault_app_bank #(
  parameter bit PAGED = 1'b1
) (
  input  wire logic                          CLK,
  input  wire logic                          RST,
  input  wire logic                          LOAD_DONE,
  input  wire fault_app_pkg::app_desc_s      APP_IN [8],
  input  wire logic [7:0]                    MEDIA_KIND_IN,
  input  wire logic [7:0]                    FAULT_REASON_IN,
  input  wire logic                          FAULT_EVENT,
  input  wire logic [7:0]                    ADDR,
  input  wire logic                          RD_EN,
  input  wire logic                          WR_EN,
  input  wire logic [7:0]                    WR_DATA,
  output      logic [7:0]                    RD_DATA,
  output      logic                          READY,
  output      logic [3:0]                    APP_COUNT
);
  app_table_if t ();
  fault_app_pkg::bank_state_e state_q;
  fault_app_pkg::bank_state_e state_d;
  logic [7:0]                 media_kind_q;
  logic [7:0]                 fault_reason_q;
  logic [3:0]                 count_d;
  logic [7:0]                 fr_d;
  logic [7:0]                 rd_d;
  logic [`APP_SLOTS-1:0]      slot_end;
  logic                       capture;
  logic                       read_taken;
  logic                       read_live;
  genvar                      g;

  // byte lookup over the frozen table
  app_lookup u_look (
    .t (t)
  );

  // **********************
  // capture sequence
  // **********************
  // the loader presents the whole table at once and raises its strobe;
  // everything is taken on that one edge, so the host can never see a
  // table that is half old and half new
  // next state; load is one-way so a late strobe cannot reopen it
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      fault_app_pkg::ST_LOAD: begin
        if (LOAD_DONE) begin
          state_d = fault_app_pkg::ST_RUN;                     // [R15]
        end
      end
      fault_app_pkg::ST_RUN: begin
        state_d = fault_app_pkg::ST_RUN;                       // [R15]
      end
    endcase
  end

  // state register, synchronous reset back to load
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= fault_app_pkg::ST_LOAD;
    end else begin
      state_q <= state_d;
    end
  end

  // the single edge on which the loader's values are taken
  assign capture = (state_q == fault_app_pkg::ST_LOAD) && LOAD_DONE;

  // media kind byte, captured together with the table
  always_ff @(posedge CLK) begin
    if (RST) begin
      media_kind_q <= `RESET_READ_VALUE;
    end else if (capture) begin
      media_kind_q <= MEDIA_KIND_IN;                           // [R7] [R15]
    end
  end

  // one capture register per slot; the first slot never ends the list
  generate
    for (g = 0; g < `APP_SLOTS; g = g + 1) begin : g_cap
      always_ff @(posedge CLK) begin
        if (RST) begin
          t.table_q[g] <= '0;
        end else if (capture) begin
          t.table_q[g] <= APP_IN[g];                           // [R3] [R15]
          // an empty first slot would advertise nothing at all
          if (g == 0 && APP_IN[g].host_code == `LIST_END_CODE) begin
            t.table_q[g].host_code <= `RESET_READ_VALUE;       // [R4]
          end
        end
      end
    end
  endgenerate

  // **********************
  // fault reason
  // **********************
  // reserved codes collapse to none so the host never reads a code
  // that has no meaning; custom codes pass through untouched
  always_comb begin
    fr_d = `FAULT_NONE;
    unique case (FAULT_REASON_IN) inside
      [`FAULT_NONE:`FAULT_KNOWN_HI]: begin
        fr_d = FAULT_REASON_IN;                                // [R1]
      end
      [`FAULT_CUSTOM_LO:`FAULT_CUSTOM_HI]: begin
        fr_d = FAULT_REASON_IN;                                // [R1]
      end
      default: begin
        fr_d = `FAULT_NONE;                                    // [R1]
      end
    endcase
  end

  // latched on entry to the failed state, cleared only by reset;
  // the first real cause wins, a reason of none leaves it open
  // limitation: a later second fault is not recorded
  always_ff @(posedge CLK) begin
    if (RST) begin
      fault_reason_q <= `FAULT_NONE;
    end else if (FAULT_EVENT && fault_reason_q == `FAULT_NONE) begin
      fault_reason_q <= PAGED ? fr_d : `FAULT_NONE;            // [R2]
    end
  end

  // **********************
  // list length
  // **********************
  // one end marker flag per slot, compared in parallel
  generate
    for (g = 0; g < `APP_SLOTS; g = g + 1) begin : g_end
      assign slot_end[g] =
        (t.table_q[g].host_code == `LIST_END_CODE);            // [R5]
    end
  endgenerate

  // entries counted up to the first end marker; without one all eight
  // slots are in use and any further entries live in extended memory,
  // which this bank does not hold
  always_comb begin
    count_d = 4'(`APP_SLOTS);                                  // [R13]
    for (int i = `APP_SLOTS - 1; i >= 0; i--) begin
      if (slot_end[i]) begin
        count_d = 4'(i);                                       // [R5]
      end
    end
  end

  // **********************
  // host read port
  // **********************
  // a read is taken on the edge that sees its strobe and answered on
  // that same edge; reads may follow back to back, one per edge, and a write
  // strobe writes nothing but cancels any read beside it
  assign t.addr = ADDR;

  // a read is taken only with no write beside it; writes never land
  assign read_taken = RD_EN && !WR_EN;                         // [R14]
  // until load completes every byte reads zero, never half a table
  assign read_live  = (state_q == fault_app_pkg::ST_RUN);      // [R15]

  // read data by address class; unmapped bytes read zero
  always_comb begin
    rd_d = `RESET_READ_VALUE;
    if (!read_live) begin
      rd_d = `RESET_READ_VALUE;                                // [R15]
    end else if (ADDR == `FAULT_REASON_ADDR) begin
      // flat memory parts carry no reason byte
      rd_d = PAGED ? fault_reason_q : `RESET_READ_VALUE;       // [R2]
    end else if (ADDR == `MEDIA_KIND_ADDR) begin
      rd_d = media_kind_q;                                     // [R6]
    end else if (t.hit) begin
      rd_d = t.data;                                           // [R3]
    end else begin
      // fifth descriptor byte and extended storage are not here
      rd_d = `RESET_READ_VALUE;                                // [R11]
    end
  end

  // held until the next taken read so a slow host may sample late
  always_ff @(posedge CLK) begin
    if (RST) begin
      RD_DATA <= `RESET_READ_VALUE;
    end else if (read_taken) begin
      RD_DATA <= rd_d;                                         // [R14]
    end
  end

  // wr_data deliberately unused: region is read only
  assign READY = read_live;

  // **********************
  // advertised count
  // **********************
  // registered so the count cannot glitch while the host reads it;
  // it costs one cycle after ready before the count is valid
  always_ff @(posedge CLK) begin
    if (RST) begin
      APP_COUNT <= 4'h0;
    end else begin
      APP_COUNT <= READY ? count_d : 4'h0;
    end
  end
endmodule : fault_app_bank

// [bench/fault_app_bank_assertions.sv]
`timescale 1ns/1ps
module fault_app_checker (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       LOAD_DONE,
  input wire logic [7:0] ADDR,
  input wire logic       RD_EN,
  input wire logic       WR_EN,
  input wire logic [7:0] RD_DATA,
  input wire logic       READY,
  input wire logic [3:0] APP_COUNT
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // a read counts only when no write rides along
  wire rd = RD_EN && !WR_EN;
  property p_early; rd && !READY |=> RD_DATA == 8'h00; endproperty
  a_early: assert property (p_early) else $error("early read");
  property p_load; LOAD_DONE && !READY |=> READY; endproperty
  a_load: assert property (p_load) else $error("no ready");
  property p_idle; !rd |=> $stable(RD_DATA); endproperty
  a_idle: assert property (p_idle) else $error("data moved");
  property p_unmap;
    rd && !(ADDR inside {8'h29, [8'h55:8'h75]}) |=> RD_DATA == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
  property p_fault;
    rd && ADDR == 8'h29 |=> RD_DATA inside {[8'h00:8'h03], [8'h20:8'h3F]};
  endproperty
  a_fault: assert property (p_fault) else $error("bad reason");
  property p_first; rd && READY && ADDR == 8'h56 |=> RD_DATA != 8'hFF;
  endproperty
  a_first: assert property (p_first) else $error("empty list");
  property p_count;
    READY && $past(READY) |-> APP_COUNT inside {[4'h1:4'h8]};
  endproperty
  a_count: assert property (p_count) else $error("bad count");
  property p_steady; READY && $past(READY) |=> $stable(APP_COUNT);
  endproperty
  a_steady: assert property (p_steady) else $error("count moved");
endmodule : fault_app_checker

bind fault_app_bank fault_app_checker i_chk (.CLK, .RST, .LOAD_DONE,
  .ADDR, .RD_EN, .WR_EN, .RD_DATA, .READY, .APP_COUNT);

// [bench/host_reader.sv]
`timescale 1ns/1ps
module host_reader (
  input  wire logic       clk,
  output      logic [7:0] addr,
  output      logic       rd_en,
  output      logic       wr_en,
  output      logic [7:0] wr_data
);
  // one access per edge; idle lines flip so stale values never pass
  task automatic acc(input logic r, w, input logic [7:0] a, d);
    @(posedge clk);
    rd_en   <= r;
    wr_en   <= w;
    addr    <= (r | w) ? a : ~addr;
    wr_data <= w ? d : ~wr_data;
  endtask : acc
  initial begin
    addr    = 8'h00;
    rd_en   = 1'b0;
    wr_en   = 1'b0;
    wr_data = 8'h00;
  end
endmodule : host_reader

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst = 1, load = 0, fev = 0, rd, wr, ready, taken_q = 0;
  logic [7:0] addr, wdat, rdat, media = 0, fcode = 0, n, f, x;
  logic [3:0] cnt;
  fault_app_pkg::app_desc_s app [8], d;
  logic [7:0] exp_q [$];
  logic [7:0] codes [4] = '{8'h07, 8'h41, 8'h2A, 8'h03};
  logic [7:0] kinds [4] = '{8'h05, 8'h40, 8'h8F, 8'h01};
  int error_cnt = 0, check_count = 0, seed = 95232;
  always #5 clk = ~clk;
  host_reader i_host (.clk(clk), .addr(addr), .rd_en(rd), .wr_en(wr),
    .wr_data(wdat));
  fault_app_bank i_dut (.CLK(clk), .RST(rst), .LOAD_DONE(load),
    .APP_IN(app), .MEDIA_KIND_IN(media), .FAULT_REASON_IN(fcode),
    .FAULT_EVENT(fev), .ADDR(addr), .RD_EN(rd), .WR_EN(wr),
    .WR_DATA(wdat), .RD_DATA(rdat), .READY(ready), .APP_COUNT(cnt));
  task automatic cmp(string s, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask : cmp
  task automatic cmp_cnt(logic [3:0] e, logic [3:0] g);
    cmp("count", {4'h0, e}, {4'h0, g});
  endtask : cmp_cnt
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // reserved codes read as no fault
  function automatic logic [7:0] filt(logic [7:0] c);
    return (c <= 8'h03 || c inside {[8'h20:8'h3F]}) ? c : 8'h00;
  endfunction : filt
  task automatic rd_chk(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    i_host.acc(1'b1, 1'b0, a, 8'h00);
  endtask : rd_chk
  // answer shows just after the taking edge and is checked on the negedge that follows
  always @(posedge clk) taken_q <= rd && !wr;
  always @(negedge clk)
    if (taken_q) cmp("rd", exp_q.pop_front(), rdat);
  // watchdog, far beyond four passes
  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    foreach (app[i]) app[i] = '0;
    for (int p = 0; p < 4; p++) begin
      i_host.acc(1'b0, 1'b0, 8'h00, 8'h00);
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      media <= kinds[p];
      foreach (app[i]) begin
        d = $random(seed);
        d.host_code = (i == ((p == 3) ? 0 : 3 * p + 1)) ? 8'hFF
                      : d.host_code & 8'hFE;
        app[i] <= d;
      end
      rd_chk(8'h56, 8'h00);
      i_host.acc(1'b0, 1'b0, 8'h00, 8'h00);
      load <= 1'b1;
      i_host.acc(1'b0, 1'b1, 8'h56, 8'hFF);
      load <= 1'b0;
      repeat (2) @(negedge clk);
      n = 8'h08;
      for (int i = 7; i >= 1; i--) if (app[i].host_code == 8'hFF) n = i[7:0];
      cmp_cnt(n[3:0], cnt);
      // media kind steers how the host reads media codes
      for (int a = 8'h54; a <= 8'h76; a++) begin
        d = app[(a - 8'h56) / 4];
        x = d[31 - 8 * ((a - 8'h56) % 4) -: 8];
        x = (a == 8'h55) ? media : (a > 8'h55 && a < 8'h76) ? x : 8'h00;
        if (a == 8'h56 && x == 8'hFF) x = 8'h00;
        rd_chk(a[7:0], x);
      end
      for (int k = 0; k < 2; k++) begin
        i_host.acc(1'b0, 1'b0, 8'h00, 8'h00);
        fcode <= k ? 8'h01 : codes[p];
        fev <= 1'b1;
        i_host.acc(1'b0, 1'b0, 8'h00, 8'h00);
        fev <= 1'b0;
        f = filt(codes[p]);
        rd_chk(8'h29, (k && f == 8'h00) ? 8'h01 : f);
      end
    end
    i_host.acc(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (2) @(negedge clk);
    report_and_stop();
  end
endmodule : tb_top
